// ==== srl_regs.svh ====
`ifndef SRL_REGS_SVH
`define SRL_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SRL_CTL_ADDR        32'hfffff890
`define SRL_LEVEL_ADDR      32'hfffff894
`define SRL_PROTECT_ADDR    32'hfffff898
`define SRL_PROTECT_KEY     8'ha5

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SRL_CTL_ENABLE_BIT  7
`define SRL_CTL_MODE_BIT    1
`define SRL_CTL_FLAG_BIT    0
`define SRL_LEVEL_SEL_BIT   0
`define SRL_CTL_RESET       8'h00
`define SRL_CTL_LVI_RESET   8'h82
`define SRL_LEVEL_RESET     8'h00
`define SRL_CLK_DIV8_CODE   3'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SRL_CLK_PERIOD_NS   100
`define SRL_SETTLE_PERIODS  65536
`define SRL_TIMER_W         17
`define SRL_WDT_HOLD_NS     1600
`define SRL_WDT_HOLD_CYCLES ((`SRL_WDT_HOLD_NS + `SRL_CLK_PERIOD_NS - 1) / `SRL_CLK_PERIOD_NS)
`define SRL_DETECT_WAIT_NS  100000

`endif

// ==== srl_pkg.sv ====
package srl_pkg;

	// Phases of the system reset sequence.
	typedef enum logic [1:0]
	{
		st_reset,
		st_settle,
		st_run
	} srl_phase_t;

	// Whole state of the reset controller.
	typedef struct packed
	{
		logic       pin_s1;
		logic       pin_s2;
		logic       below_s1;
		logic       below_s2;
		srl_phase_t phase;
		logic       enable;
		logic       mode;
		logic       level;
		logic       protect_armed;
		logic [7:0] rdata;
	} srl_core_t;

	// Whole state of one down timer.
	typedef struct packed
	{
		logic [16:0] count;
	} srl_timer_t;

endpackage

// ==== srl_timer_if.sv ====
`timescale 1ns/1ps

// Start and busy handshake between the controller and one down timer.
interface srl_timer_if;
	logic ce;
	logic start;
	logic busy;

	modport ctrl
	(
		output ce,
		output start,
		input  busy
	);

	modport timer
	(
		input  ce,
		input  start,
		output busy
	);
endinterface

// ==== srl_down_timer.sv ====
`timescale 1ns/1ps
`include "srl_regs.svh"

module srl_down_timer
#(
	parameter logic [16:0] LENGTH = 17'h00010
)
(
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	srl_timer_if.timer      tmr
);

	srl_pkg::srl_timer_t cur;
	srl_pkg::srl_timer_t nxt;

	// A start reloads the full length; otherwise count down to zero and stop there.
	always_comb
	begin
		nxt = cur;
		if (tmr.start)
		begin
			nxt.count = LENGTH;
		end
		else if (cur.count != 17'h00000)
		begin
			nxt.count = cur.count - 17'h00001;
		end
	end

	// State only moves while the clock enable is high.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cur <= '0;
		end
		else if (tmr.ce)
		begin
			cur <= nxt;
		end
	end

	// Busy reads the stored count, so it rises one edge after the start.
	assign tmr.busy = (cur.count != 17'h00000);

endmodule // srl_down_timer

// ==== srl_reset_ctrl.sv ====
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "srl_regs.svh"

// Notes on behaviour
// R1: A low reset pin holds the system in reset and initialises all hardware.
// R2: A low-to-high pin transition leaves the pin reset state.
// R3: After release, wait 2^16 oscillator periods before the CPU runs.
// R4: System and CPU clocks stop in reset, restart afterwards with divider at eight.
// R5: Peripheral clocks stay halted until the stabilisation wait has finished.
// R6: All port pins go high impedance while reset is asserted.
// R7: Reset loads every peripheral register with its initial value; an undervoltage reset here keeps the level register unchanged.
// R8: RAM keeps its contents across reset; writes are blocked meanwhile.
// R9: A watchdog overflow in reset mode causes a full system reset.
// R10: Watchdog reset lasts a fixed delay, releases itself, then stabilisation follows.
// R11: Enabled and below threshold: interrupt when mode is 0, reset when 1.
// R12: Bit 7 enables detection; clearing it stops detection.
// R13: Bit 0 is a read-only flag: 1 only when enabled and below threshold.
// R14: Control writes are accepted only inside the protected write sequence.
// R15: Control resets to 00h by pin, power-on, watchdog; to 82h by undervoltage.
// R16: Control register supports byte and single-bit accesses.
// R17: The detector keeps working in halt, idle and stop standby modes.
// R18: The detection threshold selects one of two levels.
// R19: Software waits about 0.1 ms after enabling before using the flag.
// R20: With reset mode selected, control and level are locked until another reset.
// R21: Undervoltage reset lasts while supply stays below threshold.
// R22: All three reset requests merge into one reset with the same wait.
module srl_reset_ctrl
#(
	parameter logic [16:0] SETTLE_CYCLES = 17'(`SRL_SETTLE_PERIODS)
)
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	input  wire logic        reset_pin_n,
	input  wire logic        watchdog_reset_req,
	input  wire logic        watchdog_reset_mode,
	input  wire logic        supply_below,
	input  wire logic [31:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic        reg_bit_en,
	input  wire logic [2:0]  reg_bit_sel,
	output logic      [7:0]  reg_rdata,
	output logic             sys_reset_n,
	output logic             io_hiz,
	output logic             ram_write_block,
	output logic             sys_clk_en,
	output logic             cpu_clk_en,
	output logic             periph_clk_en,
	output logic             clk_div_reset,
	output logic      [2:0]  clk_div_code,
	output logic             cpu_run,
	output logic             level_sel,
	output logic             undervoltage_flag,
	output logic             undervoltage_irq,
	output logic             undervoltage_reset_req
);

	// ------------------------------------------------------------------------
	// State and timers
	// ------------------------------------------------------------------------
	srl_pkg::srl_core_t cur;
	srl_pkg::srl_core_t nxt;

	srl_timer_if settle_if ();
	srl_timer_if wdt_if ();

	logic       pin_rst;
	logic       wdt_start;
	logic       wdt_rst;
	logic       lvi_rst;
	logic       other_rst;
	logic       any_req;
	logic       settle_busy;
	logic       in_settle;
	logic       ctl_wr;
	logic [7:0] ctl_value;
	logic [7:0] level_value;
	logic [7:0] ctl_merged;
	logic [7:0] level_merged;

	srl_down_timer
	#(
		.LENGTH (SETTLE_CYCLES)
	)
	u_settle_timer
	(
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.tmr      (settle_if.timer)
	);

	srl_down_timer
	#(
		.LENGTH (17'(`SRL_WDT_HOLD_CYCLES))
	)
	u_wdt_hold_timer
	(
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.tmr      (wdt_if.timer)
	);

	// ------------------------------------------------------------------------
	// Register helpers
	// ------------------------------------------------------------------------

	// A single-bit access changes one bit from wdata[0]; a byte access replaces all.
	function automatic logic [7:0] srl_merge
	(
		input logic [7:0] old,
		input logic [7:0] wd,
		input logic       ben,
		input logic [2:0] sel
	);
		logic [7:0] m;
		m = 8'h01 << sel;
		if (ben)
		begin
			return (old & ~m) | (wd[0] ? m : 8'h00); // R16
		end
		return wd;
	endfunction

	// Read views of the two registers; bits 2 to 6 and upper level bits read zero.
	always_comb
	begin
		ctl_value = `SRL_CTL_RESET;
		ctl_value[`SRL_CTL_ENABLE_BIT] = cur.enable;
		ctl_value[`SRL_CTL_MODE_BIT] = cur.mode;
		ctl_value[`SRL_CTL_FLAG_BIT] = undervoltage_flag;
		level_value = `SRL_LEVEL_RESET;
		level_value[`SRL_LEVEL_SEL_BIT] = cur.level;
	end

	// Merged write values are named nets, because a select on a call result is not legal.
	assign ctl_merged = srl_merge(ctl_value, reg_wdata, reg_bit_en, reg_bit_sel); // R16
	assign level_merged = srl_merge(level_value, reg_wdata, reg_bit_en, reg_bit_sel); // R16

	// ------------------------------------------------------------------------
	// Reset sources
	// ------------------------------------------------------------------------

	// The detector runs from the comparator alone, so standby modes do not stop it.
	assign undervoltage_flag = cur.enable & cur.below_s2; // R13 R17
	assign lvi_rst = undervoltage_flag & cur.mode; // R11 R21
	assign undervoltage_irq = undervoltage_flag & ~cur.mode; // R11
	assign undervoltage_reset_req = lvi_rst;
	assign level_sel = cur.level; // R18

	// The request itself covers the first cycle before the hold timer reads busy.
	assign wdt_start = watchdog_reset_req & watchdog_reset_mode; // R9
	assign wdt_rst = wdt_start | wdt_if.busy; // R10
	assign pin_rst = ~cur.pin_s2; // R1
	assign other_rst = pin_rst | wdt_rst;
	assign any_req = other_rst | lvi_rst; // R22

	assign settle_busy = settle_if.busy;
	assign in_settle = (cur.phase == srl_pkg::st_settle);
	assign ctl_wr = reg_wr & (reg_addr == `SRL_CTL_ADDR);

	// Timer handshakes; the settle wait starts on the cycle that leaves reset.
	assign settle_if.ce = clk_en;
	assign settle_if.start = (cur.phase == srl_pkg::st_reset) & ~any_req; // R3
	assign wdt_if.ce = clk_en;
	assign wdt_if.start = wdt_start; // R10

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------

	// Synchronisers, sequence, register writes and reset loads in one place.
	always_comb
	begin
		nxt = cur;
		nxt.pin_s1 = reset_pin_n;
		nxt.pin_s2 = cur.pin_s1;
		nxt.below_s1 = supply_below;
		nxt.below_s2 = cur.below_s1;

		// Any new request during the wait restarts the whole sequence.
		case (cur.phase)
			srl_pkg::st_reset:
			begin
				if (!any_req)
				begin
					nxt.phase = srl_pkg::st_settle; // R2 R10 R21
				end
			end
			srl_pkg::st_settle:
			begin
				if (any_req)
				begin
					nxt.phase = srl_pkg::st_reset; // R22
				end
				else if (!settle_busy)
				begin
					nxt.phase = srl_pkg::st_run; // R3
				end
			end
			srl_pkg::st_run:
			begin
				if (any_req)
				begin
					nxt.phase = srl_pkg::st_reset; // R1 R9 R11
				end
			end
			default:
			begin
				nxt.phase = srl_pkg::st_reset;
			end
		endcase

		// Read data stand only in the cycle after the strobe.
		nxt.rdata = 8'h00;
		if (reg_rd)
		begin
			if (reg_addr == `SRL_CTL_ADDR)
			begin
				nxt.rdata = ctl_value;
			end
			else if (reg_addr == `SRL_LEVEL_ADDR)
			begin
				nxt.rdata = level_value;
			end
			else
			begin
				nxt.rdata = 8'h00;
			end
		end

		// The key arms exactly one following write; any write disarms it.
		if (reg_wr)
		begin
			nxt.protect_armed = 1'b0;
			if (reg_addr == `SRL_PROTECT_ADDR)
			begin
				nxt.protect_armed = (reg_wdata == `SRL_PROTECT_KEY); // R14
			end
			else if (reg_addr == `SRL_CTL_ADDR)
			begin
				if (cur.protect_armed && !cur.mode) // R14 R20
				begin
					nxt.enable = ctl_merged[`SRL_CTL_ENABLE_BIT]; // R12
					nxt.mode = ctl_merged[`SRL_CTL_MODE_BIT];
				end
			end
			else if (reg_addr == `SRL_LEVEL_ADDR)
			begin
				if (!cur.mode)
				begin
					nxt.level = level_merged[`SRL_LEVEL_SEL_BIT]; // R20
				end
			end
		end

		// Reset loads win over software; undervoltage keeps the level and locks.
		if (other_rst)
		begin
			nxt.enable = 1'(`SRL_CTL_RESET >> `SRL_CTL_ENABLE_BIT); // R7 R15
			nxt.mode = 1'(`SRL_CTL_RESET >> `SRL_CTL_MODE_BIT);
			nxt.level = 1'b0;
			nxt.protect_armed = 1'b0;
		end
		else if (lvi_rst)
		begin
			nxt.enable = 1'(`SRL_CTL_LVI_RESET >> `SRL_CTL_ENABLE_BIT); // R15
			nxt.mode = 1'(`SRL_CTL_LVI_RESET >> `SRL_CTL_MODE_BIT);
			nxt.protect_armed = 1'b0;
		end
	end

	// Power-on clear is the asynchronous reset; the pin synchroniser starts low.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cur <= '0;
		end
		else if (clk_en)
		begin
			cur <= nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------

	// Clocks stay stopped through the wait; the divider is held at one eighth.
	assign sys_reset_n = (cur.phase != srl_pkg::st_reset); // R1 R7
	assign io_hiz = ~sys_reset_n; // R6
	assign ram_write_block = ~sys_reset_n; // R8
	assign cpu_run = (cur.phase == srl_pkg::st_run); // R3
	assign sys_clk_en = cpu_run; // R4
	assign cpu_clk_en = cpu_run; // R4
	assign periph_clk_en = cpu_run; // R5
	assign clk_div_reset = ~cpu_run; // R4
	assign clk_div_code = `SRL_CLK_DIV8_CODE;
	assign reg_rdata = cur.rdata;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking srl_cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_pin_holds_reset: assert property (clk_en && !cur.pin_s2 |=> !sys_reset_n) // R1
		else $error("Low reset pin did not hold the system in reset.");

	a_release_to_wait: assert property ((clk_en && !sys_reset_n && !any_req) |=> in_settle && settle_busy) // R2
		else $error("Reset release did not start the stabilisation wait.");

	a_run_after_wait: assert property ($rose(cpu_run) |-> $past(in_settle) && !$past(settle_busy)) // R3
		else $error("CPU started before the stabilisation wait ended.");

	a_clocks_stopped: assert property (!cpu_run |-> !sys_clk_en && !cpu_clk_en && clk_div_reset) // R4
		else $error("Clocks ran or divider was free outside the run phase.");

	a_periph_gated: assert property (periph_clk_en |-> cpu_run && !io_hiz) // R5
		else $error("Peripheral clock ran before the wait completed.");

	a_pins_hiz: assert property (!sys_reset_n |-> io_hiz && ram_write_block) // R6
		else $error("Pins not high impedance during reset.");

	a_wdt_reset: assert property ((clk_en && wdt_start) |=> !sys_reset_n ##1 (!clk_en || wdt_if.busy)) // R9
		else $error("Watchdog request did not reset the system.");

	a_irq_by_mode: assert property (undervoltage_irq |-> !cur.mode && cur.enable && !undervoltage_reset_req) // R11
		else $error("Undervoltage interrupt raised in the wrong mode.");

	a_flag_off: assert property (!cur.enable |-> !undervoltage_flag) // R13
		else $error("Flag set while detection disabled.");

	a_unarmed_write: assert property ((clk_en && ctl_wr && !cur.protect_armed && !other_rst && !lvi_rst)
		|=> $stable(cur.enable) && $stable(cur.mode)) // R14
		else $error("Control changed by an unprotected write.");

	a_lvi_load: assert property ((clk_en && lvi_rst && !other_rst) |=> cur.enable && cur.mode && !sys_reset_n) // R15
		else $error("Undervoltage reset did not load the control register.");

	a_locked_level: assert property ((clk_en && cur.mode && !other_rst) |=> $stable(cur.level) && cur.mode) // R20
		else $error("Locked registers changed without another reset.");

	a_lvi_hold: assert property ((clk_en && lvi_rst) |=> !sys_reset_n) // R21
		else $error("Undervoltage reset released while supply low.");

endmodule // srl_reset_ctrl

// ==== srl_far_side.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Far side: reset pin, supply comparator and watchdog
// ----------------------------------------------------------------------------
module srl_far_side
(
	input  wire logic core_clk,
	input  wire logic press,
	input  wire logic sag,
	input  wire logic bark,
	output logic      reset_pin_n,
	output logic      supply_below,
	output logic      watchdog_reset_req
);
	logic bark_d = 1'b0;

	// The pin has a pull-up, so it reads high whenever nobody presses it.
	assign reset_pin_n  = !press;
	// The comparator follows the supply with no filtering of its own.
	assign supply_below = sag;

	// One overflow gives a single-cycle request, however long the command.
	always_ff @(posedge core_clk)
	begin
		bark_d <= bark;
	end
	assign watchdog_reset_req = bark & !bark_d;
endmodule // srl_far_side

// ==== tb_top.sv ====
`timescale 1ns/1ps
`include "srl_regs.svh"

module tb_top;
	localparam logic [16:0] SETTLE = 17'h00008;
	localparam int          ST     = 8;
	logic        core_clk;
	logic        arst_n;
	logic        press;
	logic        sag;
	logic        bark;
	logic        wd_mode;
	logic        ce;
	logic        pin_n;
	logic        below;
	logic        wd_req;
	logic [31:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic        bit_en;
	logic [2:0]  bit_sel;
	logic [7:0]  reg_rdata;
	logic        sys_reset_n;
	logic        io_hiz;
	logic        ram_wb;
	logic        sys_ce;
	logic        cpu_ce;
	logic        per_ce;
	logic        div_rst;
	logic [2:0]  div_code;
	logic        cpu_run;
	logic        level_sel;
	logic        uv_flag;
	logic        uv_irq;
	logic        uv_rst;
	logic [7:0]  stat;
	int          n_fail;
	int          n_tests;
	int          n;

	srl_far_side far_u (.core_clk(core_clk), .press(press), .sag(sag), .bark(bark),
		.reset_pin_n(pin_n), .supply_below(below), .watchdog_reset_req(wd_req));

	srl_reset_ctrl #(.SETTLE_CYCLES(SETTLE)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
		.clk_en(ce), .reset_pin_n(pin_n), .watchdog_reset_req(wd_req),
		.watchdog_reset_mode(wd_mode), .supply_below(below), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bit_en(bit_en),
		.reg_bit_sel(bit_sel), .reg_rdata(reg_rdata), .sys_reset_n(sys_reset_n),
		.io_hiz(io_hiz), .ram_write_block(ram_wb), .sys_clk_en(sys_ce), .cpu_clk_en(cpu_ce),
		.periph_clk_en(per_ce), .clk_div_reset(div_rst), .clk_div_code(div_code),
		.cpu_run(cpu_run), .level_sel(level_sel), .undervoltage_flag(uv_flag),
		.undervoltage_irq(uv_irq), .undervoltage_reset_req(uv_rst));

	// Clock and pin status packed so one compare covers them: 1f in reset, e3 in run.
	assign stat = {per_ce, sys_ce, cpu_ce, div_rst, io_hiz, ram_wb, div_code[1:0]};

	always #50 core_clk = !core_clk;

	// ------------------------------------------------------------------------
	// Bus and checking tasks
	// ------------------------------------------------------------------------
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// The read data stand only in the cycle after the strobe, so sample there.
	task automatic rdchk(input logic [31:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Key and control write stay back to back, with the strobe held up between.
	task automatic prot(input logic [7:0] d, input logic ben, input logic [2:0] sel);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= `SRL_PROTECT_ADDR;
		reg_wdata <= `SRL_PROTECT_KEY;
		@(posedge core_clk);
		reg_addr  <= `SRL_CTL_ADDR;
		reg_wdata <= d;
		bit_en    <= ben;
		bit_sel   <= sel;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		bit_en <= 1'b0;
	endtask

	// Bounded wait on the system reset (which 0) or the run flag (which 1).
	task automatic await(input int which, input logic lvl, output int cnt);
		cnt = 0;
		while (((which == 0) ? sys_reset_n : cpu_run) !== lvl)
		begin
			@(posedge core_clk);
			#1;
			cnt++;
			if (cnt > 300)
			begin
				n_fail++;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, !lvl, lvl);
				end_of_test();
			end
		end
	endtask

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		press = 1'b1;
		{sag, bark, reg_wr, reg_rd, bit_en} = 5'h00;
		wd_mode = 1'b0;
		ce = 1'b1;
		reg_addr = 32'h00000000;
		reg_wdata = 8'h00;
		bit_sel = 3'h0;
		n_fail = 0;
		n_tests = 0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		rdchk(`SRL_CTL_ADDR, 8'h00);
		rdchk(`SRL_LEVEL_ADDR, 8'h00);
		rdchk(32'hfffff8a0, 8'h00);
		chk(stat, 8'h1f);
		prot(8'h80, 1'b0, 3'h0);
		rdchk(`SRL_CTL_ADDR, 8'h00);
		@(posedge core_clk);
		press <= 1'b0;
		await(1, 1'b1, n);
		chk(8'(n >= ST + 1 && n <= ST + 8), 8'h01);
		chk(stat, 8'he3);
		$display("test pin release done");
		// Key lost to an unrelated write between key and control.
		wr(`SRL_CTL_ADDR, 8'h80);
		wr(`SRL_PROTECT_ADDR, `SRL_PROTECT_KEY);
		wr(32'hfffff8a0, 8'h00);
		wr(`SRL_CTL_ADDR, 8'h80);
		rdchk(`SRL_CTL_ADDR, 8'h00);
		prot(8'hfd, 1'b0, 3'h0);
		rdchk(`SRL_CTL_ADDR, 8'h80);
		sag <= 1'b1;
		repeat (`SRL_DETECT_WAIT_NS / `SRL_CLK_PERIOD_NS) @(posedge core_clk);
		rdchk(`SRL_CTL_ADDR, 8'h81);
		chk({6'h00, uv_irq, uv_rst}, 8'h02);
		wr(`SRL_LEVEL_ADDR, 8'h01);
		rdchk(`SRL_LEVEL_ADDR, 8'h01);
		chk({7'h00, level_sel}, 8'h01);
		prot(8'h00, 1'b1, 3'h7);
		rdchk(`SRL_CTL_ADDR, 8'h00);
		chk({6'h00, uv_irq, uv_flag}, 8'h00);
		$display("test registers done");
		// Enable first and let the detector settle before reset mode is chosen.
		prot(8'h80, 1'b0, 3'h0);
		repeat (`SRL_DETECT_WAIT_NS / `SRL_CLK_PERIOD_NS) @(posedge core_clk);
		prot(8'h82, 1'b0, 3'h0);
		await(0, 1'b0, n);
		chk({7'h00, uv_rst}, 8'h01);
		rdchk(`SRL_CTL_ADDR, 8'h83);
		prot(8'h00, 1'b0, 3'h0);
		wr(`SRL_LEVEL_ADDR, 8'h00);
		rdchk(`SRL_CTL_ADDR, 8'h83);
		rdchk(`SRL_LEVEL_ADDR, 8'h01);
		chk(stat, 8'h1f);
		sag <= 1'b0;
		await(1, 1'b1, n);
		chk(8'(n >= ST + 1 && n <= ST + 8), 8'h01);
		rdchk(`SRL_CTL_ADDR, 8'h82);
		$display("test undervoltage reset done");
		// A watchdog overflow outside reset mode must be ignored.
		@(posedge core_clk);
		bark <= 1'b1;
		@(posedge core_clk);
		bark <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk({7'h00, sys_reset_n}, 8'h01);
		wd_mode <= 1'b1;
		bark <= 1'b1;
		@(posedge core_clk);
		bark <= 1'b0;
		await(0, 1'b0, n);
		chk(8'(n <= 4), 8'h01);
		await(1, 1'b1, n);
		chk(8'(n >= ST + 12 && n <= ST + 24), 8'h01);
		rdchk(`SRL_CTL_ADDR, 8'h00);
		rdchk(`SRL_LEVEL_ADDR, 8'h00);
		prot(8'h80, 1'b0, 3'h0);
		rdchk(`SRL_CTL_ADDR, 8'h80);
		$display("test watchdog done");
		// With the clock enable low the pin press must not move any state.
		@(posedge core_clk);
		ce <= 1'b0;
		press <= 1'b1;
		repeat (6) @(posedge core_clk);
		chk({6'h00, cpu_run, sys_reset_n}, 8'h03);
		ce <= 1'b1;
		await(0, 1'b0, n);
		chk(stat, 8'h1f);
		rdchk(`SRL_CTL_ADDR, 8'h00);
		@(posedge core_clk);
		press <= 1'b0;
		await(1, 1'b1, n);
		chk(stat, 8'he3);
		$display("test pin in run done");
		end_of_test();
	end
endmodule // tb_top
